/* shared/ovcl_pkg.sv */
// Purpose: Constants and types shared by the output-voltage command logic
// Assumes: Command codes arrive as 8-bit values from the bus engine
// Notes: Voltages are held internally in 2^-12 V units
package ovcl_pkg;
    localparam logic [7:0] OVCL_CMD_MODE = 8'h20;
    localparam logic [7:0] OVCL_CMD_TARGET = 8'h21;
    localparam logic [7:0] OVCL_CMD_OFFSET = 8'h22;
    localparam logic [7:0] OVCL_CMD_CEILING = 8'h24;
    localparam logic [7:0] OVCL_CMD_RATE = 8'h27;
    localparam int OVCL_W = 16;
    localparam int OVCL_IW = 20;
    localparam int OVCL_REL_BIT = 7;
    localparam int OVCL_EXP_HI = 4;
    localparam logic signed [5:0] OVCL_EXP_MIN = -6'sd12;
    localparam logic signed [5:0] OVCL_EXP_MAX = -6'sd4;
    localparam logic [7:0] OVCL_MODE_RESET = 8'h14;
    localparam logic [15:0] OVCL_RATE_RESET = 16'he010;
    localparam logic [15:0] OVCL_CEIL_RESET = 16'h6000;
    localparam logic [15:0] OVCL_FLOOR_RESET = 16'h0000;
    localparam int OVCL_NV_OFS_MAX = 127;
    localparam int OVCL_NV_OFS_MIN = -128;
    // DAC ceiling per loop scale, millivolts
    localparam int OVCL_DAC_MV_S0 = 700;
    localparam int OVCL_DAC_MV_S1 = 1400;
    localparam int OVCL_DAC_MV_S2 = 2800;
    localparam int OVCL_DAC_MV_S3 = 6000;
    localparam int OVCL_UNITS_PER_V = 4096;
    localparam int OVCL_CLK_HZ = 20000000;
    // Rate counts 0.0625 mV/us; one internal step is 1/4096 V
    localparam int OVCL_RATE_NUM = 16;
    typedef enum logic [1:0] {
        OVCL_IDLE = 2'b00,
        OVCL_RAMP = 2'b01,
        OVCL_CONV = 2'b10
    } ovcl_state_t;
endpackage

/* hdl/ovcl_sync.sv */
`timescale 1ns/1ps
// Purpose: Three-stage pin synchroniser with agreement check
// Assumes: Input is asynchronous to clk
// Notes: Output changes only when stages two and three agree
module ovcl_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic s1, s2, s3;
    logic next_dout;
    always_comb begin
        next_dout = dout;
        if (s2 == s3) begin
            next_dout = s3;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule

/* hdl/ovcl_slew.sv */
`timescale 1ns/1ps
// Purpose: Ramps the DAC code toward a goal at the programmed rate
// Assumes: Goal and code in 2^-12 V units
// Notes: Accumulates rate*256000 per clock; steps when one unit gathers
module ovcl_slew import ovcl_pkg::*; #(
    parameter int IW = OVCL_IW,
    parameter int ACC_W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [IW-1:0] goal,
    input wire logic [10:0] rate,
    input wire logic jump,
    output logic [IW-1:0] code,
    output logic busy
);
    // Units per second per rate count = 0.0625e-3*1e6*4096 = 256000
    localparam logic [ACC_W-1:0] ACC_ONE = ACC_W'(OVCL_CLK_HZ);
    localparam int STEP_PER_CNT = 256000;
    logic [ACC_W-1:0] acc, next_acc;
    logic [IW-1:0] next_code;
    logic [ACC_W-1:0] add;
    always_comb begin
        add = ACC_W'(rate) * ACC_W'(STEP_PER_CNT);
        next_acc = acc;
        next_code = code;
        busy = (code != goal);
        if (jump) begin
            next_code = goal;
            next_acc = '0;
        end else if (code == goal) begin
            next_acc = '0;
        end else if (acc + add >= ACC_ONE) begin
            // Fast rates step every clock; no residue kept, so no overflow
            next_acc = (add >= ACC_ONE) ? '0 : acc + add - ACC_ONE;
            next_code = (goal > code) ? code + IW'(1) : code - IW'(1);
        end else begin
            next_acc = acc + add;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc <= '0;
            code <= '0;
        end else begin
            acc <= next_acc;
            code <= next_code;
        end
    end
endmodule

/* hdl/ovcl_top.sv */
`timescale 1ns/1ps
// Purpose: Output-voltage target, offset and ceiling command logic
// Assumes: A bus engine presents decoded word writes and reads
// Notes: Internal voltages use 2^-12 V; values held as host words
// How it works
// - Changing the format converts stored voltage words to the new exponent.
// - Written words use the format in force at write time.
// - Code 21h holds unsigned target, word write and read.
// - Target changes ramp at the programmed transition rate; a fault restart with restore bit set jumps the DAC.
// - Reset pin input restores boot voltage into the target.
// - Boot default from NVM when override is 0, strap when 1.
// - Boot voltage is kept apart from the live target.
// - Fault restart keeps target, or reloads boot when restore bit set.
// - Target plus offset outside limits clamps DAC and raises warning.
// - Code 22h holds signed offset added to the target.
// - Offset changes ramp at the same transition rate.
// - Offset saved to NVM as 8-bit signed, exponent -12, saturated.
// - Above DAC maximum but under ceiling clamps silently at DAC max.
// - DAC range set by loop scale: 0.7, 1.4, 2.8, 6.0 V.
// - Offset write outside valid range flags invalid data.
// - Offset write beyond limits clamps DAC and raises warning.
// - Code 24h ceiling caps the ramp goal; the output can be above it until the ramp settles.
// - Format exponent is 5-bit signed, linear only, -4 to -12.
// - Format bit 7 marks absolute (0) or relative (1); it is stored and read back but changes no output.
// - Transition rate exponent fixed at -4, 0.0625 mV/us per count.
module ovcl_top import ovcl_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] CMD,
    input wire logic [15:0] WR_DATA,
    output logic [15:0] RD_DATA,
    output logic RD_ACK,
    input wire logic [15:0] NVM_TARGET,
    input wire logic [7:0] NVM_OFFSET,
    input wire logic [15:0] STRAP_TARGET,
    input wire logic STRAP_OVERRIDE_SELECT,
    input wire logic FAULT_RESTORE_DEFAULT,
    input wire logic RESET_PIN_MODE,
    input wire logic POWER_GOOD_OR_RESET_PIN_N,
    input wire logic RESTORE_USER_ALL,
    input wire logic FAULT_RESTART,
    input wire logic [1:0] LOOP_SCALE,
    input wire logic [15:0] FLOOR,
    output logic [7:0] NVM_OFFSET_SAVE,
    output logic [OVCL_IW-1:0] DAC_CODE,
    output logic RAMP_BUSY,
    output logic LIMIT_WARN,
    output logic INVALID_DATA,
    output logic NOTIFY
);
    logic rst_a, rst_n;
    logic pin_reset;
    logic [15:0] target, offset, ceiling, rate, boot_voltage;
    logic [7:0] mode;
    logic [15:0] next_target, next_offset, next_ceiling, next_rate, next_boot;
    logic [7:0] next_mode;
    logic next_warn, next_inv, next_notify;
    logic [15:0] rd_word;
    logic pin_hold, next_pin_hold;
    logic boot_load, next_boot_load;
    logic signed [OVCL_IW+1:0] sum_v, ceil_v, floor_v, dac_v;
    logic [OVCL_IW-1:0] goal;
    logic [15:0] boot_src;
    logic [7:0] next_nvm_save;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_a <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_n <= rst_a;
        end
    end

    ovcl_sync u_pin (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .din(~POWER_GOOD_OR_RESET_PIN_N),
        .dout(pin_reset)
    );

    function automatic logic signed [OVCL_IW+1:0] to_units(
        input logic [15:0] w, input logic sgn, input logic [7:0] m);
        logic signed [5:0] e;
        logic signed [OVCL_IW+1:0] v;
        logic [3:0] sh;
        e = {m[OVCL_EXP_HI], m[OVCL_EXP_HI:0]};
        v = sgn ? (OVCL_IW+2)'(signed'(w)) : (OVCL_IW+2)'(w);
        sh = 4'(e - OVCL_EXP_MIN);
        return v <<< sh;
    endfunction

    // re-express a units value under a new exponent
    function automatic logic [15:0] from_units(
        input logic signed [OVCL_IW+1:0] v, input logic [7:0] m);
        logic signed [5:0] e;
        logic [3:0] sh;
        e = {m[OVCL_EXP_HI], m[OVCL_EXP_HI:0]};
        sh = 4'(e - OVCL_EXP_MIN);
        return 16'(v >>> sh);
    endfunction

    function automatic logic signed [OVCL_IW+1:0] dac_max(input logic [1:0] s);
        int mv;
        case (s)
            2'h0: mv = OVCL_DAC_MV_S0;
            2'h1: mv = OVCL_DAC_MV_S1;
            2'h2: mv = OVCL_DAC_MV_S2;
            default: mv = OVCL_DAC_MV_S3;
        endcase
        return (OVCL_IW+2)'(mv * OVCL_UNITS_PER_V / 1000);
    endfunction

    function automatic logic exp_ok(input logic [7:0] m);
        logic signed [5:0] e;
        e = {m[OVCL_EXP_HI], m[OVCL_EXP_HI:0]};
        return (e >= OVCL_EXP_MIN) && (e <= OVCL_EXP_MAX) && (m[6:5] == 2'b00);
    endfunction

    assign boot_src = STRAP_OVERRIDE_SELECT ? STRAP_TARGET : NVM_TARGET;

    always_comb begin
        sum_v = to_units(target, 1'b0, mode) + to_units(offset, 1'b1, mode);
        ceil_v = to_units(ceiling, 1'b0, mode);
        floor_v = to_units(FLOOR, 1'b0, mode);
        dac_v = sum_v;
        if (sum_v > ceil_v) begin
            dac_v = ceil_v;
        end else if (sum_v < floor_v) begin
            dac_v = floor_v;
        end
        if (dac_v > dac_max(LOOP_SCALE)) begin
            dac_v = dac_max(LOOP_SCALE);
        end
        if (dac_v < 0) begin
            dac_v = '0;
        end
        goal = OVCL_IW'(dac_v);
    end

    ovcl_slew u_slew (
        .clk(SYS_CLK),
        .rst_n(rst_n),
        .goal(goal),
        .rate(rate[10:0]),
        .jump(boot_load),
        .code(DAC_CODE),
        .busy(RAMP_BUSY)
    );

    always_comb begin
        next_target = target;
        next_offset = offset;
        next_ceiling = ceiling;
        next_rate = rate;
        next_mode = mode;
        next_boot = boot_voltage;
        next_warn = LIMIT_WARN;
        next_inv = INVALID_DATA;
        next_notify = 1'b0;
        next_pin_hold = pin_reset;
        next_boot_load = 1'b0;
        if (sum_v > ceil_v || sum_v < floor_v) begin
            next_warn = 1'b1;
            next_notify = !LIMIT_WARN;
        end
        if (RD_STB && CMD == OVCL_CMD_TARGET) begin
            next_warn = next_warn;
        end
        if (WR_STB) begin
            case (CMD)
                OVCL_CMD_TARGET: next_target = WR_DATA;
                OVCL_CMD_OFFSET: begin
                    if (to_units(WR_DATA, 1'b1, mode) > dac_max(LOOP_SCALE) ||
                        to_units(WR_DATA, 1'b1, mode) < -dac_max(LOOP_SCALE)) begin
                        next_inv = 1'b1;
                        next_notify = 1'b1;
                    end else begin
                        next_offset = WR_DATA;
                    end
                end
                OVCL_CMD_CEILING: next_ceiling = WR_DATA;
                OVCL_CMD_RATE: next_rate = {OVCL_RATE_RESET[15:11], WR_DATA[10:0]};
                OVCL_CMD_MODE: begin
                    if (exp_ok(WR_DATA[7:0])) begin
                        next_mode = {WR_DATA[OVCL_REL_BIT], 2'b00, WR_DATA[4:0]};
                        next_target = from_units(to_units(target, 1'b0, mode),
                            WR_DATA[7:0]);
                        next_offset = from_units(to_units(offset, 1'b1, mode),
                            WR_DATA[7:0]);
                        next_ceiling = from_units(to_units(ceiling, 1'b0, mode),
                            WR_DATA[7:0]);
                        next_boot = from_units(to_units(boot_voltage, 1'b0, mode),
                            WR_DATA[7:0]);
                    end else begin
                        next_inv = 1'b1;
                        next_notify = 1'b1;
                    end
                end
                default: next_inv = next_inv;
            endcase
        end
        if (RESTORE_USER_ALL) begin
            next_boot = boot_src;
            next_target = boot_src;
        end
        if (FAULT_RESTART && FAULT_RESTORE_DEFAULT) begin
            next_target = boot_voltage;
            next_boot_load = 1'b1;
        end
        if (RESET_PIN_MODE && pin_reset) begin
            next_target = boot_voltage;
        end
    end

    // NVM copy at exponent -12, saturated
    always_comb begin
        logic signed [OVCL_IW+1:0] ov;
        ov = to_units(offset, 1'b1, mode);
        if (ov > OVCL_NV_OFS_MAX) begin
            next_nvm_save = 8'(OVCL_NV_OFS_MAX);
        end else if (ov < OVCL_NV_OFS_MIN) begin
            next_nvm_save = 8'(OVCL_NV_OFS_MIN);
        end else begin
            next_nvm_save = 8'(ov);
        end
    end

    // Saved copy leaves from a flip-flop
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            NVM_OFFSET_SAVE <= 8'h00;
        end else begin
            NVM_OFFSET_SAVE <= next_nvm_save;
        end
    end

    always_comb begin
        case (CMD)
            OVCL_CMD_MODE: rd_word = {8'h00, mode};
            OVCL_CMD_TARGET: rd_word = target;
            OVCL_CMD_OFFSET: rd_word = offset;
            OVCL_CMD_CEILING: rd_word = ceiling;
            OVCL_CMD_RATE: rd_word = rate;
            default: rd_word = 16'h0000;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            target <= 16'h0000;
            offset <= 16'h0000;
            ceiling <= OVCL_CEIL_RESET;
            rate <= OVCL_RATE_RESET;
            mode <= OVCL_MODE_RESET;
            boot_voltage <= 16'h0000;
            LIMIT_WARN <= 1'b0;
            INVALID_DATA <= 1'b0;
            NOTIFY <= 1'b0;
            pin_hold <= 1'b0;
            boot_load <= 1'b1;
            RD_DATA <= 16'h0000;
            RD_ACK <= 1'b0;
        end else if (boot_load && !pin_hold && target == 16'h0000 &&
                     boot_voltage == 16'h0000) begin
            // first cycle after reset takes boot source
            target <= boot_src;
            boot_voltage <= boot_src;
            boot_load <= 1'b0;
            pin_hold <= 1'b1;
            RD_ACK <= 1'b0;
            NOTIFY <= 1'b0;
        end else begin
            target <= next_target;
            offset <= next_offset;
            ceiling <= next_ceiling;
            rate <= next_rate;
            mode <= next_mode;
            boot_voltage <= next_boot;
            LIMIT_WARN <= next_warn;
            INVALID_DATA <= next_inv;
            NOTIFY <= next_notify;
            pin_hold <= next_pin_hold;
            boot_load <= next_boot_load;
            RD_DATA <= RD_STB ? rd_word : RD_DATA;
            RD_ACK <= RD_STB;
        end
    end
endmodule

/* tb/ovcl_chk.sv */
// Purpose: Port-level checks of the output-voltage command logic
// Assumes: Ceiling is written only while the exponent is -12
// Notes: Ceiling is tracked in 2^-12 V units from bus writes
`timescale 1ns/1ps
module ovcl_chk import ovcl_pkg::*; (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [7:0] CMD,
    input wire logic [15:0] WR_DATA,
    input wire logic [15:0] RD_DATA,
    input wire logic RD_ACK,
    input wire logic FAULT_RESTART,
    input wire logic [1:0] LOOP_SCALE,
    input wire logic [OVCL_IW-1:0] DAC_CODE,
    input wire logic RAMP_BUSY,
    input wire logic LIMIT_WARN,
    input wire logic INVALID_DATA,
    input wire logic NOTIFY
);
    localparam int DMV[4] = '{OVCL_DAC_MV_S0, OVCL_DAC_MV_S1, OVCL_DAC_MV_S2, OVCL_DAC_MV_S3};
    logic [15:0] ceil;
    logic [2:0] up_cnt;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ceil <= OVCL_CEIL_RESET;
            up_cnt <= 3'h0;
        end else begin
            if (WR_STB && CMD == OVCL_CMD_CEILING) begin
                ceil <= WR_DATA;
            end
            if (up_cnt != 3'h4) begin
                up_cnt <= up_cnt + 3'h1;
            end
        end
    end
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);
    property p_rd_ack;
        RD_STB |=> RD_ACK;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read without ack");
    property p_rd_hold;
        !RD_ACK |-> $stable(RD_DATA);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read word moved");
    property p_ramp_step;
        (up_cnt == 3'h4 && !$past(FAULT_RESTART) && !$past(FAULT_RESTART, 2)
            && !$past(FAULT_RESTART, 3))
            |-> (DAC_CODE - $past(DAC_CODE)) inside {20'h00001, 20'h00000, 20'hfffff};
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("dac stepped");
    property p_move_busy;
        DAC_CODE != $past(DAC_CODE) |-> $past(RAMP_BUSY);
    endproperty
    a_move_busy: assert property (p_move_busy) else $error("dac moved idle");
    property p_ceiling;
        !RAMP_BUSY |-> DAC_CODE <= OVCL_IW'(ceil);
    endproperty
    a_ceiling: assert property (p_ceiling) else $error("dac above ceiling");
    property p_dac_range;
        !RAMP_BUSY |-> DAC_CODE <= DMV[LOOP_SCALE] * OVCL_UNITS_PER_V / 1000;
    endproperty
    a_dac_range: assert property (p_dac_range) else $error("dac above range");
    property p_warn_sticky;
        LIMIT_WARN |=> LIMIT_WARN;
    endproperty
    a_warn_sticky: assert property (p_warn_sticky) else $error("warn dropped");
    property p_inv_sticky;
        INVALID_DATA |=> INVALID_DATA;
    endproperty
    a_inv_sticky: assert property (p_inv_sticky) else $error("invalid dropped");
    property p_notify;
        $rose(LIMIT_WARN) |-> NOTIFY;
    endproperty
    a_notify: assert property (p_notify) else $error("warn without notify");
endmodule
bind ovcl_top ovcl_chk i_ovcl_chk (.SYS_CLK, .NRST, .WR_STB, .RD_STB, .CMD, .WR_DATA,
    .RD_DATA, .RD_ACK, .FAULT_RESTART, .LOOP_SCALE, .DAC_CODE, .RAMP_BUSY, .LIMIT_WARN,
    .INVALID_DATA, .NOTIFY);

/* tb/ovcl_host.sv */
// Purpose: Bus host model issuing word writes and reads
// Assumes: One strobe cycle per request
// Notes: Expected read words are queued for the bench monitor
`timescale 1ns/1ps
module ovcl_host (
    input wire logic SYS_CLK,
    output logic WR_STB,
    output logic RD_STB,
    output logic [7:0] CMD,
    output logic [15:0] WR_DATA
);
    logic [15:0] exp_q[$];
    initial begin
        WR_STB = 1'b0;
        RD_STB = 1'b0;
        CMD = 8'h00;
        WR_DATA = 16'h0000;
    end
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge SYS_CLK);
        WR_STB <= 1'b1;
        CMD <= c;
        WR_DATA <= d;
        @(posedge SYS_CLK);
        WR_STB <= 1'b0;
        CMD <= ~c;
        WR_DATA <= ~d;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge SYS_CLK);
        RD_STB <= 1'b1;
        CMD <= c;
        @(posedge SYS_CLK);
        RD_STB <= 1'b0;
        CMD <= ~c;
    endtask
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench for the output-voltage command logic
// Assumes: Exponent -12 except in the format step
// Notes: Reads are checked by a monitor against queued words
`timescale 1ns/1ps
module testbench import ovcl_pkg::*;;
    logic SYS_CLK, NRST, WR_STB, RD_STB, RD_ACK, RAMP_BUSY, LIMIT_WARN, INVALID_DATA, NOTIFY;
    logic STRAP_OVERRIDE_SELECT, FAULT_RESTORE_DEFAULT, RESET_PIN_MODE, RESTORE_USER_ALL;
    logic POWER_GOOD_OR_RESET_PIN_N, FAULT_RESTART;
    logic [7:0] CMD, NVM_OFFSET, NVM_OFFSET_SAVE;
    logic [15:0] WR_DATA, RD_DATA, NVM_TARGET, STRAP_TARGET, FLOOR, t;
    logic [OVCL_IW-1:0] DAC_CODE;
    logic [1:0] LOOP_SCALE;
    logic [15:0] ofs[4] = '{16'h0005, 16'h0200, 16'hff80, 16'h0000};
    logic [7:0] sav[4] = '{8'h05, 8'h7f, 8'h80, 8'h00};
    int num_errors = 0;
    int checked = 0;
    int n;
    integer seed;
    ovcl_top i_ovcl_top (.SYS_CLK, .NRST, .WR_STB, .RD_STB, .CMD, .WR_DATA, .RD_DATA, .RD_ACK,
        .NVM_TARGET, .NVM_OFFSET, .STRAP_TARGET, .STRAP_OVERRIDE_SELECT, .FAULT_RESTORE_DEFAULT,
        .RESET_PIN_MODE, .POWER_GOOD_OR_RESET_PIN_N, .RESTORE_USER_ALL, .FAULT_RESTART,
        .LOOP_SCALE, .FLOOR, .NVM_OFFSET_SAVE, .DAC_CODE, .RAMP_BUSY, .LIMIT_WARN,
        .INVALID_DATA, .NOTIFY);
    ovcl_host i_ovcl_host (.SYS_CLK, .WR_STB, .RD_STB, .CMD, .WR_DATA);
    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic settle;
        n = 0;
        repeat (3) @(negedge SYS_CLK);
        while (RAMP_BUSY !== 1'b0 && n < 20000) begin
            @(negedge SYS_CLK);
            n++;
        end
    endtask
    always @(negedge SYS_CLK) begin
        if (RD_ACK === 1'b1 && i_ovcl_host.exp_q.size() > 0) begin
            cmp({16'h0, RD_DATA}, {16'h0, i_ovcl_host.exp_q.pop_front()});
        end
    end
    initial begin
        repeat (90000) @(posedge SYS_CLK);
        num_errors++;
        close_out();
    end
    initial begin
        seed = 32'ha7eec2fb;
        {NRST, STRAP_OVERRIDE_SELECT, FAULT_RESTORE_DEFAULT, RESET_PIN_MODE} = 4'h0;
        {RESTORE_USER_ALL, FAULT_RESTART, POWER_GOOD_OR_RESET_PIN_N} = 3'h1;
        {NVM_TARGET, STRAP_TARGET, FLOOR, NVM_OFFSET} = {16'h0100, 16'h0180, 16'h0000, 8'h00};
        LOOP_SCALE = 2'h3;
        repeat (3) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
        i_ovcl_host.rd(OVCL_CMD_TARGET, 16'h0100);
        i_ovcl_host.rd(OVCL_CMD_CEILING, OVCL_CEIL_RESET);
        settle();
        cmp(32'(DAC_CODE), 32'h100);
        for (int i = 0; i < 4; i++) begin
            t = 16'h0200 + 16'($random(seed) & 32'h00ff);
            i_ovcl_host.wr(OVCL_CMD_TARGET, t);
            i_ovcl_host.rd(OVCL_CMD_TARGET, t);
        end
        settle();
        cmp({31'h0, RAMP_BUSY}, 32'h0);
        cmp(32'(DAC_CODE), 32'(t));
        for (int i = 0; i < 4; i++) begin
            i_ovcl_host.wr(OVCL_CMD_OFFSET, ofs[i]);
            @(negedge SYS_CLK);
            cmp({31'h0, RAMP_BUSY}, 32'h1);
            i_ovcl_host.rd(OVCL_CMD_OFFSET, ofs[i]);
            cmp(32'(NVM_OFFSET_SAVE), 32'(sav[i]));
            settle();
            cmp(32'(DAC_CODE), 32'(t) + 32'($signed(ofs[i])));
        end
        i_ovcl_host.wr(OVCL_CMD_TARGET, 16'h0100);
        i_ovcl_host.wr(OVCL_CMD_MODE, 16'h0018);
        i_ovcl_host.rd(OVCL_CMD_TARGET, 16'h0010);
        i_ovcl_host.wr(OVCL_CMD_TARGET, 16'h0020);
        i_ovcl_host.wr(OVCL_CMD_MODE, 16'h0014);
        i_ovcl_host.rd(OVCL_CMD_TARGET, 16'h0200);
        i_ovcl_host.rd(OVCL_CMD_CEILING, OVCL_CEIL_RESET);
        i_ovcl_host.wr(OVCL_CMD_TARGET, 16'h0300);
        RESET_PIN_MODE <= 1'b1;
        POWER_GOOD_OR_RESET_PIN_N <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
        POWER_GOOD_OR_RESET_PIN_N <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        i_ovcl_host.rd(OVCL_CMD_TARGET, 16'h0100);
        i_ovcl_host.wr(OVCL_CMD_TARGET, 16'h0240);
        i_ovcl_host.wr(8'h23, 16'h1234);
        for (int i = 0; i < 2; i++) begin
            FAULT_RESTORE_DEFAULT <= i[0];
            @(posedge SYS_CLK) FAULT_RESTART <= 1'b1;
            @(posedge SYS_CLK) FAULT_RESTART <= 1'b0;
            repeat (4) @(posedge SYS_CLK);
            i_ovcl_host.rd(OVCL_CMD_TARGET, i == 0 ? 16'h0240 : 16'h0100);
        end
        STRAP_OVERRIDE_SELECT <= 1'b1;
        @(posedge SYS_CLK) RESTORE_USER_ALL <= 1'b1;
        @(posedge SYS_CLK) RESTORE_USER_ALL <= 1'b0;
        i_ovcl_host.rd(OVCL_CMD_TARGET, 16'h0180);
        settle();
        cmp(32'(DAC_CODE), 32'h180);
        LOOP_SCALE <= 2'h0;
        i_ovcl_host.wr(OVCL_CMD_TARGET, 16'h0c00);
        settle();
        cmp(32'(DAC_CODE), OVCL_DAC_MV_S0 * OVCL_UNITS_PER_V / 1000);
        cmp({31'h0, LIMIT_WARN}, 32'h0);
        i_ovcl_host.wr(OVCL_CMD_OFFSET, 16'h7fff);
        i_ovcl_host.rd(OVCL_CMD_OFFSET, 16'h0000);
        cmp({31'h0, INVALID_DATA}, 32'h1);
        LOOP_SCALE <= 2'h3;
        i_ovcl_host.wr(OVCL_CMD_CEILING, 16'h0a00);
        settle();
        cmp(32'(DAC_CODE), 32'h0a00);
        cmp({31'h0, LIMIT_WARN}, 32'h1);
        cmp(i_ovcl_host.exp_q.size(), 32'h0);
        close_out();
    end
endmodule
